//--- inc/adcm_pkg.sv
// Shared constants and carrier types for the multiplexed converter control.
// Assumes a single 20 MHz system clock and an APB register port.
`default_nettype none

package adcm_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int RES_W = 10;                 // Result word width.
    localparam int HALF_W = 5;                 // Coarse and fine widths.
    localparam int CHAN_W = 3;                 // Channel index width.
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 50;
    localparam int MIN_CONV_PERIOD_NS = 500;   // 2 MHz sampling ceiling.
    localparam int MIN_CONV_CYC =
        (MIN_CONV_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int GAP_W = 5;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
    localparam logic [APB_AW-1:0] REG_RESULT = 12'h008;

    localparam int CTRL_PIPE_BIT = 0;          // 1 = pipelined mode.
    localparam int CTRL_START_BIT = 1;         // Write 1: one conversion.
    localparam logic CTRL_PIPE_RST = 1'b0;

    localparam int ST_CHAN_LSB = 0;
    localparam int ST_PWRDN_BIT = 3;
    localparam int ST_PEND_BIT = 4;
    localparam int ST_FINE_BIT = 5;
    localparam int ST_RATE_BIT = 6;            // Write 1 to clear.

    localparam int RES_OVER_BIT = 10;

    localparam logic [CHAN_W-1:0] CHAN_FIRST = 3'h0;  // Analog input one.
    localparam logic [RES_W-1:0] RES_RST = 10'h000;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic select_reset_n;
        logic write_strobe_n;
        logic channel_addr_bit_hi;
        logic channel_addr_bit_mid;
        logic channel_addr_bit_lo;
    } adcm_sel_pins_t;

    typedef struct packed {
        logic overrange_flag;
        logic [RES_W-1:0] data;
    } adcm_result_t;

    typedef enum logic [0:0] {
        CV_IDLE,
        CV_FINE
    } adcm_conv_state_t;

endpackage : adcm_pkg

`default_nettype wire

//--- hdl/adcm_top.sv
// Digital control of an eight-input multiplexed 10-bit converter.
// Assumes pins arrive asynchronously, an APB master on SYS_CLK, and a
// front end that presents the selected input's code on AIN_CODE.
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`default_nettype none

module adcm_top
    import adcm_pkg::*;
#(
    parameter int MIN_GAP = MIN_CONV_CYC
) (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RST,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [APB_AW-1:0] PADDR,
    input wire logic [APB_DW-1:0] PWDATA,
    output logic [APB_DW-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Channel selection pins.
    input wire adcm_sel_pins_t SEL_PINS,
    output logic [CHAN_W-1:0] CHANNEL_SEL,
    // Conversion pins.
    input wire logic CONV_CLK,
    input wire logic POWER_DOWN,
    input wire logic RESULT_OE_N,
    input wire logic [RES_W-1:0] AIN_CODE,
    input wire logic AIN_OVER,
    // Result pins: the data word and the overrange flag each have their own drive enable.
    output adcm_result_t RESULT_BUS,
    output logic RESULT_BUS_OE,
    output logic OVERRANGE_FLAG_OE
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int SEL_W = $bits(adcm_sel_pins_t);
    localparam int SYNC_W = SEL_W + 4 + RES_W;
    // The output enable starts inactive, so the result pins do not turn
    // on for the two cycles in which the real pin level is in flight.
    localparam logic [SYNC_W-1:0] SYNC_RST =
        {SEL_W'(0), 1'b0, 1'b0, 1'b1, 1'b0, RES_W'(0)};

    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    adcm_sel_pins_t sel_s;
    logic conv_clk_s;
    logic pwr_dn_s;
    logic oe_n_s;
    logic over_s;
    logic [RES_W-1:0] code_s;

    // Every pin passes two flops; only the second stage is read.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            sync_a <= SYNC_RST;
            sync_b <= SYNC_RST;
        end else begin
            sync_a <= {SEL_PINS, CONV_CLK, POWER_DOWN, RESULT_OE_N,
                       AIN_OVER, AIN_CODE};
            sync_b <= sync_a;
        end
    end

    assign {sel_s, conv_clk_s, pwr_dn_s, oe_n_s, over_s, code_s} = sync_b;

    // ------------------------------------------------------------
    // Channel selection latch
    // ------------------------------------------------------------
    logic [CHAN_W-1:0] channel;

    // Clear has priority over the strobe, as on the pins.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            channel <= CHAN_FIRST;
        end else if (!sel_s.select_reset_n) begin
            channel <= CHAN_FIRST;
        end else if (!sel_s.write_strobe_n) begin
            channel <= {sel_s.channel_addr_bit_hi,
                        sel_s.channel_addr_bit_mid,
                        sel_s.channel_addr_bit_lo};
        end
    end

    assign CHANNEL_SEL = channel;

    // ------------------------------------------------------------
    // Conversion clock edges and rate check
    // ------------------------------------------------------------
    logic conv_prev;
    logic conv_rise;
    logic conv_fall;
    logic [GAP_W-1:0] gap_cnt;
    logic gap_ok;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            conv_prev <= 1'b0;
        end else begin
            conv_prev <= conv_clk_s;
        end
    end

    assign conv_rise = conv_clk_s & ~conv_prev;
    assign conv_fall = ~conv_clk_s & conv_prev;

    // Counts cycles since the last rising edge, saturating at the limit.
    // Saturation keeps a long idle spell from wrapping into a refusal.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            gap_cnt <= GAP_W'(MIN_GAP);
        end else if (conv_rise) begin
            gap_cnt <= '0;
        end else if (gap_cnt < GAP_W'(MIN_GAP)) begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    // An edge sooner than the 2 MHz period is ignored, not half-used.
    assign gap_ok = (gap_cnt >= GAP_W'(MIN_GAP - 1));

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    logic apb_setup;
    logic apb_wr;
    logic hit_ctrl;
    logic hit_status;
    logic hit_result;
    logic pipe_mode;
    logic start_req;
    logic rate_err;

    assign apb_setup = PSEL & ~PENABLE;
    assign apb_wr = PSEL & PENABLE & PWRITE;

    // One compare serves every register decode.
    function automatic logic reg_hit(input logic [APB_AW-1:0] addr,
        input logic [APB_AW-1:0] offset);
        return addr == offset;
    endfunction

    assign hit_ctrl = reg_hit(PADDR, REG_CTRL);
    assign hit_status = reg_hit(PADDR, REG_STATUS);
    assign hit_result = reg_hit(PADDR, REG_RESULT);

    // Zero wait states: read data is captured in the setup cycle.
    assign PREADY = 1'b1;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pipe_mode <= CTRL_PIPE_RST;
        end else if (apb_wr && hit_ctrl) begin
            pipe_mode <= PWDATA[CTRL_PIPE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    adcm_conv_state_t state;
    logic take;
    logic [HALF_W-1:0] coarse_buf;
    logic over_buf;
    adcm_result_t result;

    // Pipelined mode converts on every rising edge that passes the rate check; on-demand waits for a start.
    assign take = conv_rise & gap_ok & (pipe_mode | start_req);

    // A start written in the cycle it is consumed is kept for next edge.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            start_req <= 1'b0;
        end else if (apb_wr && hit_ctrl && PWDATA[CTRL_START_BIT]) begin
            start_req <= 1'b1;
        end else if (take) begin
            start_req <= 1'b0;
        end
    end

    // Sticky flag for conversion edges arriving faster than allowed.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rate_err <= 1'b0;
        end else if (conv_rise && !gap_ok) begin
            rate_err <= 1'b1;
        end else if (apb_wr && hit_status && PWDATA[ST_RATE_BIT]) begin
            rate_err <= 1'b0;
        end
    end

    // Coarse half on the rising edge, fine half on the falling edge.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state <= CV_IDLE;
        end else begin
            case (state)
                CV_IDLE: begin
                    if (take) begin
                        state <= CV_FINE;
                    end
                end
                CV_FINE: begin
                    if (conv_fall) begin
                        state <= CV_IDLE;
                    end
                end
                default: begin
                    state <= CV_IDLE;
                end
            endcase
        end
    end

    // The coarse buffer holds the upper half until the fine step ends.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            coarse_buf <= '0;
            over_buf <= 1'b0;
        end else if (state == CV_IDLE && take) begin
            coarse_buf <= code_s[RES_W-1 -: HALF_W];
            over_buf <= over_s;
        end
    end

    // Results update only outside power-down, so the pins stay frozen.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            result <= '{overrange_flag: 1'b0, data: RES_RST};
        end else if (state == CV_FINE && conv_fall
                     && !pwr_dn_s) begin
            result.data <= {coarse_buf, code_s[HALF_W-1:0]};
            result.overrange_flag <= over_buf;
        end
    end

    // ------------------------------------------------------------
    // Result pins
    // ------------------------------------------------------------
    // Bit 9 of the word is the MSB pin, bit 0 the LSB pin.
    assign RESULT_BUS = result;

    // Drive enables follow the synchronised active-low output enable.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            RESULT_BUS_OE <= 1'b0;
            OVERRANGE_FLAG_OE <= 1'b0;
        end else begin
            RESULT_BUS_OE <= ~oe_n_s;
            OVERRANGE_FLAG_OE <= ~oe_n_s;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [APB_DW-1:0] next_rdata;
    logic next_err;

    // Unmapped addresses read zero and raise the slave error.
    always_comb begin
        next_rdata = '0;
        next_err = 1'b0;
        if (hit_ctrl) begin
            next_rdata[CTRL_PIPE_BIT] = pipe_mode;
        end else if (hit_status) begin
            next_rdata[ST_CHAN_LSB +: CHAN_W] = channel;
            next_rdata[ST_PWRDN_BIT] = pwr_dn_s;
            next_rdata[ST_PEND_BIT] = start_req;
            next_rdata[ST_FINE_BIT] = (state == CV_FINE);
            next_rdata[ST_RATE_BIT] = rate_err;
        end else if (hit_result) begin
            next_rdata[RES_W-1:0] = result.data;
            next_rdata[RES_OVER_BIT] = result.overrange_flag;
        end else begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else if (apb_setup) begin
            PRDATA <= PWRITE ? '0 : next_rdata;
            PSLVERR <= next_err;
        end
    end

endmodule : adcm_top

`default_nettype wire

//--- dv/adcm_monitor.sv
// Port checker for adcm_top, attached by the bind below.
// Assumes one clock and pins that pass a two-flop synchroniser.
`default_nettype none
// ---
// Checker
// ---
module adcm_monitor
    import adcm_pkg::*;
#(
    parameter int MIN_GAP = MIN_CONV_CYC
) (
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RST,
    // Pins watched.
    input wire adcm_sel_pins_t SEL_PINS,
    input wire logic [CHAN_W-1:0] CHANNEL_SEL,
    input wire logic CONV_CLK,
    input wire logic POWER_DOWN,
    input wire logic RESULT_OE_N,
    input wire adcm_result_t RESULT_BUS,
    input wire logic RESULT_BUS_OE,
    input wire logic OVERRANGE_FLAG_OE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    // A pin level shows three edges on, so each wait counts sync stages.
    a_clear_first: assert property (
        (!SEL_PINS.select_reset_n)[*3] |=> CHANNEL_SEL == CHAN_FIRST)
        else $error("clear missed");
    a_strobe_load: assert property (
        (SEL_PINS[4:3] == 2'b10 && $stable(SEL_PINS))[*4]
        |-> CHANNEL_SEL == SEL_PINS[2:0])
        else $error("address not loaded");
    a_select_hold: assert property (
        (SEL_PINS[4:3] == 2'b11)[*3] |=> $stable(CHANNEL_SEL))
        else $error("selection moved");
    a_oe_drive: assert property (
        (!RESULT_OE_N)[*3] |=> RESULT_BUS_OE && OVERRANGE_FLAG_OE)
        else $error("outputs not driven");
    a_oe_release: assert property (
        RESULT_OE_N[*3] |=> !RESULT_BUS_OE && !OVERRANGE_FLAG_OE)
        else $error("outputs not released");
    a_oe_pair: assert property (
        !$past(RST, 1) && !$past(RST, 2) && !$past(RST, 3)
        |-> RESULT_BUS_OE == OVERRANGE_FLAG_OE
            && RESULT_BUS_OE == !$past(RESULT_OE_N, 3))
        else $error("enables differ");
    a_pwrdn_freeze: assert property (
        POWER_DOWN[*5] |=> $stable(RESULT_BUS.data))
        else $error("result moved in power-down");
    a_idle_hold: assert property (
        (!CONV_CLK)[*8] |=> $stable(RESULT_BUS))
        else $error("result moved without clock");

    // Main scenarios reached.
    c_load: cover property (!SEL_PINS.write_strobe_n ##4 CHANNEL_SEL == 3'h7);
    c_freeze: cover property (POWER_DOWN && $fell(CONV_CLK));
    c_update: cover property (!$stable(RESULT_BUS.data));
endmodule // adcm_monitor

bind adcm_top adcm_monitor #(.MIN_GAP(MIN_GAP)) adcm_monitor_inst (
    .SYS_CLK(SYS_CLK), .RST(RST), .SEL_PINS(SEL_PINS),
    .CHANNEL_SEL(CHANNEL_SEL), .CONV_CLK(CONV_CLK),
    .POWER_DOWN(POWER_DOWN), .RESULT_OE_N(RESULT_OE_N),
    .RESULT_BUS(RESULT_BUS), .RESULT_BUS_OE(RESULT_BUS_OE),
    .OVERRANGE_FLAG_OE(OVERRANGE_FLAG_OE));
`default_nettype wire

//--- dv/adcm_host_model.sv
// Host model: drives the selection pins, resolves the result pins.
// Assumes go is high for a single cycle at a time.
`default_nettype none
// ---
// Host
// ---
module adcm_host_model
    import adcm_pkg::*;
(
    // Bench requests.
    input wire logic clk,
    input wire logic go,
    input wire logic sel_clear,
    input wire logic [CHAN_W-1:0] addr,
    // Device side.
    output var adcm_sel_pins_t pins,
    input wire adcm_result_t bus,
    input wire logic bus_oe,
    input wire logic flag_oe,
    output logic [RES_W:0] bus_wire
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] hold = 3'h0;

    initial pins = 5'h18;

    // A request stands six cycles, past the synchroniser; then the
    // address lines fall to their pull-down level and the strobe is
    // driven high, so a lazy selection latch would show.
    always @(posedge clk) begin
        if (go) begin
            hold <= 3'h6;
            pins <= {!sel_clear, 1'b0, addr};
        end else if (hold > 3'h1) begin
            hold <= hold - 3'h1;
        end else begin
            pins <= 5'h18;
        end
    end

    // Undriven result pins float.
    assign bus_wire = {flag_oe ? bus.overrange_flag : 1'bz,
        bus_oe ? bus.data : 10'bz};
endmodule // adcm_host_model
`default_nettype wire

//--- dv/tb_adcm_top.sv
// Self-checking bench for adcm_top with a host model at its pins.
// Assumes the checker binds itself to adcm_top.
`default_nettype none
// ---
// Bench
// ---
module tb_adcm_top
    import adcm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic conv_clk, pwr_dn, oe_n, ain_over, go, sel_clear, look, bus_oe;
    logic flag_oe;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata;
    logic [CHAN_W-1:0] addr, chan, ch;
    logic [RES_W-1:0] ain;
    logic [RES_W:0] res, bus_wire;
    adcm_sel_pins_t pins;
    adcm_result_t bus;
    logic [65:0] rq[$];
    logic [13:0] pq[$];
    int mismatches, samples_checked;

    adcm_top #(.MIN_GAP(MIN_CONV_CYC)) adcm_top_inst (
        .SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SEL_PINS(pins),
        .CHANNEL_SEL(chan), .CONV_CLK(conv_clk), .POWER_DOWN(pwr_dn),
        .RESULT_OE_N(oe_n), .AIN_CODE(ain), .AIN_OVER(ain_over),
        .RESULT_BUS(bus), .RESULT_BUS_OE(bus_oe),
        .OVERRANGE_FLAG_OE(flag_oe));
    adcm_host_model adcm_host_model_inst (
        .clk(clk), .go(go), .sel_clear(sel_clear), .addr(addr),
        .pins(pins), .bus(bus), .bus_oe(bus_oe), .flag_oe(flag_oe),
        .bus_wire(bus_wire));

    always #25 clk = ~clk;

    // Notes are compared as results appear, oldest first.
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && rq.size() > 0) begin
            chk_reg(rq.pop_front());
        end
        if (look) begin
            chk_pin(pq.pop_front());
        end
    end

    task automatic chk_reg(input logic [65:0] n);
        samples_checked++;
        if (({pslverr, prdata} & n[65:33]) !== n[32:0]) begin
            mismatches++;
            $display("ERROR apb exp %h got %h", n[32:0], {pslverr, prdata});
        end
    endtask

    task automatic chk_pin(input logic [13:0] e);
        samples_checked++;
        if ({chan, bus_wire} !== e) begin
            mismatches++;
            $display("ERROR pins exp %h got %h", e, {chan, bus_wire});
        end
    endtask

    // One transfer, then an idle edge so psel is never set twice at once.
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] m,
        input logic [32:0] e);
        rq.push_back({m, e});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic look_pins();
        pq.push_back({ch, oe_n ? 11'bz : res});
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask

    task automatic sel(input logic c, input logic [2:0] a);
        sel_clear <= c;
        addr <= a;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        ch = c ? CHAN_FIRST : a;
        repeat (9) @(posedge clk);
        look_pins();
    endtask

    // Upper code is held over the rise, lower code over the fall.
    task automatic conv(input logic ok);
        logic [9:0] a;
        logic [9:0] b;
        logic ov;
        a = 10'($urandom);
        b = 10'($urandom);
        ov = 1'($urandom);
        ain <= a;
        ain_over <= ov;
        conv_clk <= 1'b1;
        repeat (4) @(posedge clk);
        ain <= b;
        repeat (2) @(posedge clk);
        conv_clk <= 1'b0;
        repeat (6) @(posedge clk);
        if (ok && !pwr_dn) res = {ov, a[9:5], b[4:0]};
        look_pins();
    endtask

    // Two conversion clock rises well inside the minimum period; the
    // second must be refused and flagged, the result left alone.
    task automatic rate_burst();
        repeat (2) begin
            conv_clk <= 1'b1;
            repeat (2) @(posedge clk);
            conv_clk <= 1'b0;
            repeat (2) @(posedge clk);
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence.
    initial begin
        {clk, psel, penable, pwrite, conv_clk, pwr_dn, oe_n, ain_over} = '0;
        {go, sel_clear, look, paddr, pwdata, addr, ain, res, ch} = '0;
        rst = 1'b1;
        void'($urandom(13217));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        look_pins();
        for (int i = 0; i < 8; i++) begin
            sel(1'b0, 3'h7 - i[2:0]);
        end
        sel(1'b1, 3'h5);
        rd(REG_CTRL, 33'h1, 33'h0);
        rd(12'h00c, '1, 33'h100000000);
        conv(1'b0);
        rate_burst();
        rd(REG_STATUS, {1'b1, 32'h7f}, 33'h40);
        apb(1'b1, REG_STATUS, 32'h40);
        rd(REG_STATUS, {1'b1, 32'h7f}, 33'h0);
        apb(1'b1, REG_CTRL, 32'h2);
        conv(1'b1);
        rd(REG_RESULT, {1'b1, 32'h7ff}, {22'h0, res});
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (3) conv(1'b1);
        pwr_dn <= 1'b1;
        repeat (5) @(posedge clk);
        conv(1'b1);
        pwr_dn <= 1'b0;
        oe_n <= 1'b1;
        repeat (4) @(posedge clk);
        look_pins();
        results();
    end

    // A hang counts as a failure; the run needs under 1000 cycles.
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        results();
    end
endmodule // tb_adcm_top
`default_nettype wire
